// ### rtl/pmc_axil_wr.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_axil_wr
  import pmc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wr_take,
  output logic             wr_valid,
  output pmc_wr_s          wr_req
);

  logic aw_held;
  logic w_held;

  // Each channel is free while nothing of it is held
  assign awready  = !aw_held;
  assign wready   = !w_held;
  assign wr_valid = aw_held && w_held;

  // Address channel holder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held     <= 1'b0;
      wr_req.addr <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      aw_held     <= 1'b1;
      wr_req.addr <= awaddr;
    end
    else if (wr_take)
      aw_held <= 1'b0;
  end

  // Data channel holder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held      <= 1'b0;
      wr_req.data <= 32'h00000000;
      wr_req.strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held      <= 1'b1;
      wr_req.data <= wdata;
      wr_req.strb <= wstrb;
    end
    else if (wr_take)
      w_held <= 1'b0;
  end

endmodule // pmc_axil_wr
`default_nettype wire

// ### rtl/pmc_pkg.sv
`default_nettype none
package pmc_pkg;

  // Register byte offsets
  localparam logic [7:0] PMC_OFF_CAP = 8'h80;
  localparam logic [7:0] PMC_OFF_CTL = 8'h84;

  // Fixed identity of the capability
  localparam logic [7:0] PMC_CAP_ID  = 8'h01;
  localparam logic [7:0] PMC_NEXT_UP = 8'h9C;
  localparam logic [7:0] PMC_NEXT_DN = 8'h8C;
  localparam logic [2:0] PMC_VERSION = 3'h3;

  // Field positions, first doubleword
  localparam int PMC_B_NEXT   = 8;
  localparam int PMC_B_VER    = 16;
  localparam int PMC_B_PMECLK = 19;
  localparam int PMC_B_DSI    = 21;
  localparam int PMC_B_AUX    = 22;
  localparam int PMC_B_D1     = 25;
  localparam int PMC_B_D2     = 26;
  localparam int PMC_B_PMESUP = 27;

  // Field positions, second doubleword
  localparam int PMC_B_STATE  = 0;
  localparam int PMC_B_NSR    = 3;
  localparam int PMC_B_PME_EN = 8;
  localparam int PMC_B_DSEL   = 9;
  localparam int PMC_B_DSCALE = 13;
  localparam int PMC_B_PME_ST = 15;
  localparam int PMC_B_B2B3   = 22;
  localparam int PMC_B_BPCC   = 23;
  localparam int PMC_B_DATA   = 24;

  // Reset values of writable fields
  localparam logic [3:0] PMC_DSEL_RST   = 4'h0;
  localparam logic       PMC_PME_EN_RST = 1'b0;

  // AXI responses
  localparam logic [1:0] PMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;

  // Power states
  typedef enum logic [1:0] {
    PMC_D0    = 2'h0,
    PMC_D1    = 2'h1,
    PMC_D2    = 2'h2,
    PMC_D3HOT = 2'h3
  } pmc_pstate_e;

  // Loadable defaults of the read-only fields
  typedef struct packed {
    logic       dsi;
    logic [2:0] aux;
    logic       d1;
    logic       d2;
    logic [4:0] pme_sup;
    logic       nsr;
    logic [7:0] data;
  } pmc_dflt_s;

  localparam pmc_dflt_s PMC_DFLT_RST = '{dsi: 1'b0, aux: 3'h7, d1: 1'b1, d2: 1'b1,
                                         pme_sup: 5'h1F, nsr: 1'b1, data: 8'h00};

  // One collected write
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pmc_wr_s;

endpackage
`default_nettype wire

// ### rtl/pmc_regs.sv
// Operation
// RL1 - Capability identifier byte always reads the power management code.
// RL2 - Next pointer resets to one offset upstream, another downstream.
// RL3 - Version field reads the fixed revision 1.2 code.
// RL4 - Legacy PME clock and bridge bus-power bits read zero.
// RL5 - Device-specific-initialization bit defaults to zero.
// RL6 - Read-only defaults are reloadable from SMBus or EEPROM and read back.
// RL7 - Auxiliary current field defaults to all ones.
// RL8 - D1 and D2 support bits default to one.
// RL9 - PME support field defaults to all ones.
// RL10 - Power-state field is writable, resets to D0, encodes D0 to D3hot.
// RL11 - Writing D0 from D3hot causes hot reset without downstream reset pin.
// RL12 - Skip-internal-reset flag resets to one and gates the internal reset.
// RL13 - PME enable is sticky, resets to zero, enables PME messages.
// RL14 - PME status always reads zero.
// RL15 - Data byte is read-only with loadable default.
// RL16 - Read-only and reserved fields ignore writes; reserved reads zero.
// RL17 - Data-select writable, resets zero; data-scale reads zero.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pmc_regs
  import pmc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        port_is_upstream,
  input  wire logic        smbus_load,
  input  wire pmc_dflt_s   smbus_dflt,
  input  wire logic        eeprom_load,
  input  wire pmc_dflt_s   eeprom_dflt,
  output pmc_pstate_e      power_state,
  output logic             pme_msg_enable,
  output logic [3:0]       data_select,
  output logic             hot_reset,
  output logic             internal_reset,
  output logic             downstream_reset_out_n
);

  // Read word of the first doubleword
  function automatic logic [31:0] cap_word(input logic [7:0] nxt, input pmc_dflt_s d);
    logic [31:0] w;
    w = 32'h00000000;
    w[7:0] = PMC_CAP_ID; // RL1
    w[PMC_B_NEXT +: 8] = nxt; // RL2
    w[PMC_B_VER +: 3] = PMC_VERSION; // RL3
    w[PMC_B_PMECLK] = 1'b0; // RL4
    w[PMC_B_DSI] = d.dsi; // RL5
    w[PMC_B_AUX +: 3] = d.aux; // RL7
    w[PMC_B_D1] = d.d1; // RL8
    w[PMC_B_D2] = d.d2; // RL8
    w[PMC_B_PMESUP +: 5] = d.pme_sup; // RL9
    return w;
  endfunction

  // Read word of the second doubleword
  function automatic logic [31:0] ctl_word(input pmc_pstate_e st, input logic pe,
                                           input logic [3:0] ds, input pmc_dflt_s d);
    logic [31:0] w;
    w = 32'h00000000; // RL16
    w[PMC_B_STATE +: 2] = st;
    w[PMC_B_NSR] = d.nsr;
    w[PMC_B_PME_EN] = pe;
    w[PMC_B_DSEL +: 4] = ds;
    w[PMC_B_DSCALE +: 2] = 2'h0; // RL17
    w[PMC_B_PME_ST] = 1'b0; // RL14
    w[PMC_B_B2B3] = 1'b0; // RL4
    w[PMC_B_BPCC] = 1'b0; // RL4
    w[PMC_B_DATA +: 8] = d.data; // RL15
    return w;
  endfunction

  logic        wr_valid;
  pmc_wr_s     wr_req;
  logic        wr_take;
  logic        wr_ctl;
  logic        wr_hit;
  logic        leave_d3;
  logic [7:0]  next_ptr;
  pmc_dflt_s   dflt;
  logic        rd_ctl;
  logic        rd_cap;
  logic        strap_meta;
  logic        strap_sync;

  // Write channel collector, address and data in either order
  pmc_axil_wr u_wr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awvalid  (awvalid),
    .awready  (awready),
    .awaddr   (awaddr),
    .wvalid   (wvalid),
    .wready   (wready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wr_take  (wr_take),
    .wr_valid (wr_valid),
    .wr_req   (wr_req)
  );

  // Write decode
  assign wr_take  = wr_valid && !bvalid;
  assign wr_ctl   = wr_req.addr == PMC_OFF_CTL;
  assign wr_hit   = wr_ctl || (wr_req.addr == PMC_OFF_CAP);
  assign leave_d3 = wr_take && wr_ctl && wr_req.strb[0] && (power_state == PMC_D3HOT)
                    && (wr_req.data[PMC_B_STATE +: 2] == PMC_D0);

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= PMC_RESP_OKAY;
    end
    else if (wr_take)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Strap pin passes two flip-flops before the pointer logic reads it
  always_ff @(posedge aclk)
  begin
    strap_meta <= port_is_upstream;
    strap_sync <= strap_meta;
  end

  // Port direction strap, caught while reset is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      next_ptr <= strap_sync ? PMC_NEXT_UP : PMC_NEXT_DN; // RL2
  end

  // Loadable defaults, EEPROM wins a tie
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dflt <= PMC_DFLT_RST; // RL5 RL7 RL8 RL9 RL12
    else if (eeprom_load)
      dflt <= eeprom_dflt; // RL6 RL12 RL15
    else if (smbus_load)
      dflt <= smbus_dflt; // RL6 RL15
  end

  // Power state field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_state <= PMC_D0; // RL10
    else if (wr_take && wr_ctl && wr_req.strb[0])
      power_state <= pmc_pstate_e'(wr_req.data[PMC_B_STATE +: 2]); // RL10
  end

  // Sticky PME enable, cleared only by power-on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pme_msg_enable <= PMC_PME_EN_RST; // RL13
    else if (wr_take && wr_ctl && wr_req.strb[1])
      pme_msg_enable <= wr_req.data[PMC_B_PME_EN]; // RL13
  end

  // Data select, also cleared by the internal reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_select <= PMC_DSEL_RST; // RL17
    else if (leave_d3 && !dflt.nsr)
      data_select <= PMC_DSEL_RST; // RL12
    else if (wr_take && wr_ctl && wr_req.strb[1])
      data_select <= wr_req.data[PMC_B_DSEL +: 4]; // RL17
  end

  // Reset pulses on leaving D3hot; the downstream pin stays high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hot_reset              <= 1'b0;
      internal_reset         <= 1'b0;
      downstream_reset_out_n <= 1'b1;
    end
    else
    begin
      hot_reset              <= leave_d3; // RL11
      internal_reset         <= leave_d3 && !dflt.nsr; // RL12
      downstream_reset_out_n <= 1'b1; // RL11
    end
  end

  // Read channel, one word per request
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= PMC_RESP_OKAY;
      rd_cap <= 1'b0;
      rd_ctl <= 1'b0;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rd_cap <= araddr == PMC_OFF_CAP;
      rd_ctl <= araddr == PMC_OFF_CTL;
      case (araddr)
        PMC_OFF_CAP:
        begin
          rdata <= cap_word(next_ptr, dflt);
          rresp <= PMC_RESP_OKAY;
        end
        PMC_OFF_CTL:
        begin
          rdata <= ctl_word(power_state, pme_msg_enable, data_select, dflt);
          rresp <= PMC_RESP_OKAY;
        end
        default:
        begin
          rdata <= 32'h00000000;
          rresp <= PMC_RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Properties sample on the block clock and rest while reset is held
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Capability word read back
  a_cap_id_read: assert property (rvalid && rd_cap |-> rdata[7:0] == PMC_CAP_ID) // RL1
    else $error("capability id wrong");
  a_next_ptr_dir: assert property (rvalid && rd_cap |-> rdata[15:8] == next_ptr // RL2
    && (next_ptr == PMC_NEXT_UP || next_ptr == PMC_NEXT_DN))
    else $error("next pointer wrong");
  a_version_code: assert property (rvalid && rd_cap |-> rdata[18:16] == 3'h3) // RL3
    else $error("version code wrong");
  a_fixed_zeros: assert property (rvalid && (rd_cap || rd_ctl) |-> // RL4
    (rd_cap ? (rdata[19] == 1'b0 && rdata[20] == 1'b0) : (rdata[23:22] == 2'h0)))
    else $error("hardwired bit not zero");

  // Default loading and read back of the loaded fields
  a_dflt_load: assert property (smbus_load && !eeprom_load |=> dflt == $past(smbus_dflt)) // RL6
    else $error("smbus default not loaded");
  a_eeprom_wins: assert property (eeprom_load |=> dflt == $past(eeprom_dflt)) // RL6
    else $error("eeprom default not loaded");
  a_cap_read_back: assert property (rvalid && rd_cap && $past(arvalid && arready) |-> // RL6
    rdata[31:21] == {$past(dflt.pme_sup), $past(dflt.d2), $past(dflt.d1), $past(dflt.aux),
    $past(dflt.dsi)})
    else $error("loaded default not read back");

  // Power state writes and the reset pulses on leaving D3hot
  a_state_write: assert property (wr_take && wr_ctl && wr_req.strb[0] |=> // RL10
    power_state == $past(wr_req.data[1:0]) && bvalid)
    else $error("power state write lost");
  a_hot_reset: assert property (hot_reset |-> power_state == PMC_D0 // RL11
    && $past(power_state) == PMC_D3HOT && downstream_reset_out_n)
    else $error("hot reset without D3hot exit");
  a_d3_exit: assert property (leave_d3 |=> hot_reset ##1 !hot_reset) // RL11
    else $error("hot reset pulse missing");
  a_int_reset: assert property (leave_d3 |=> internal_reset == !$past(dflt.nsr)) // RL12
    else $error("internal reset gating wrong");
  a_pme_enable: assert property (wr_take && wr_ctl && wr_req.strb[1] |=> // RL13
    pme_msg_enable == $past(wr_req.data[8]))
    else $error("pme enable write lost");

  // Control word fixed and reserved bits
  a_pme_status: assert property (rvalid && rd_ctl |-> rdata[15] == 1'b0 // RL14
    && (rdata[3] == dflt.nsr || $past(eeprom_load || smbus_load)))
    else $error("pme status not zero");
  a_data_byte: assert property (rvalid && rd_ctl && $stable(dflt) && $past(rvalid) == 1'b0 // RL15
    |-> rdata[31:24] == dflt.data)
    else $error("data byte wrong");
  a_ro_stable: assert property (wr_take && !wr_ctl |=> $stable(power_state) // RL16
    && $stable(pme_msg_enable) && $stable(data_select))
    else $error("read-only write changed state");
  a_reserved_zero: assert property (rvalid && rd_ctl |-> rdata[21:16] == 6'h00 // RL16
    && rdata[7:4] == 4'h0 && rdata[2] == 1'b0 && rdata[14:13] == 2'h0) // RL17
    else $error("reserved bits not zero");

  // Bus refusals and responses
  a_unmapped_err: assert property (arvalid && arready && araddr != PMC_OFF_CAP // RL16
    && araddr != PMC_OFF_CTL |=> rvalid && rresp == PMC_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rresp_okay: assert property (rvalid && (rd_cap || rd_ctl) |-> rresp == PMC_RESP_OKAY) // RL16
    else $error("mapped read refused");
  a_write_resp: assert property (wr_take |=> bvalid // RL16
    && bresp == ($past(wr_hit) ? PMC_RESP_OKAY : PMC_RESP_SLVERR))
    else $error("write response wrong");
  a_ro_defaults: assert property (wr_take && !wr_ctl |=> $stable(next_ptr) // RL16
    && ($stable(dflt) || $past(eeprom_load || smbus_load)))
    else $error("read-only default changed by write");

  // Writable fields hold unless written
  a_pstate_hold: assert property (!(wr_take && wr_ctl && wr_req.strb[0]) |=> $stable(power_state)) // RL10
    else $error("power state changed without write");
  a_pme_sticky: assert property (!(wr_take && wr_ctl && wr_req.strb[1]) |=> $stable(pme_msg_enable)) // RL13
    else $error("pme enable changed without write");

  // Data select write and its clearing by the internal reset
  a_dsel_clear: assert property (leave_d3 && !dflt.nsr |=> data_select == PMC_DSEL_RST) // RL12
    else $error("data select not cleared");
  a_dsel_write: assert property (wr_take && wr_ctl && wr_req.strb[1] && !(leave_d3 && !dflt.nsr) // RL17
    |=> data_select == $past(wr_req.data[12:9]))
    else $error("data select write lost");
  a_irst_with_hot: assert property (internal_reset |-> hot_reset) // RL12
    else $error("internal reset without hot reset");

  // Control word carries the state seen when the read was taken
  a_ctl_read_back: assert property (rvalid && rd_ctl && $past(arvalid && arready) |-> // RL10
    rdata[1:0] == $past(power_state) && rdata[8] == $past(pme_msg_enable)
    && rdata[12:9] == $past(data_select)) // RL13 RL17
    else $error("control word read back wrong");

  // Main scenarios reached
  c_d3_exit: cover property (power_state == PMC_D3HOT ##[1:20] hot_reset);
  c_int_reset: cover property (internal_reset);
  c_both_loads: cover property (eeprom_load && smbus_load);
  c_ctl_read: cover property (rvalid && rd_ctl && pme_msg_enable);
  c_slverr_write: cover property (bvalid && bresp == PMC_RESP_SLVERR);

endmodule // pmc_regs
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pmc_pkg::*;
;
  logic        aclk    = 1'h0;
  logic        aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic        bready  = 1'h1, rready = 1'h1;
  logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hF;
  logic        up      = 1'h1, sm_ld = 1'h0, ee_ld = 1'h0;
  // Alternate defaults offered by the two load paths
  pmc_dflt_s   sm_d    = '{1'h1, 3'h5, 1'h1, 1'h0, 5'h15, 1'h1, 8'hA5};
  pmc_dflt_s   ee_d    = '{1'h1, 3'h2, 1'h0, 1'h0, 5'h0A, 1'h0, 8'h5A};
  logic        awready, wready, bvalid, arready, rvalid, pme_en, hot, irst, dsr_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  dsel;
  pmc_pstate_e pst;
  int          err_count = 0, checks_done = 0, cyc = 0;
  int          hot_cnt = 0, irst_cnt = 0, dsr_low = 0;

  pmc_regs i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .port_is_upstream(up),
    .smbus_load(sm_ld), .smbus_dflt(sm_d), .eeprom_load(ee_ld), .eeprom_dflt(ee_d),
    .power_state(pst), .pme_msg_enable(pme_en), .data_select(dsel), .hot_reset(hot),
    .internal_reset(irst), .downstream_reset_out_n(dsr_n)
  );

  // Clock generation
  always #12.5 aclk = ~aclk;

  // Pulse and pin monitors, sampled mid-cycle
  always @(negedge aclk)
  begin
    if (hot === 1'h1) hot_cnt++;
    if (irst === 1'h1) irst_cnt++;
    if (dsr_n !== 1'h1) dsr_low++;
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected capability word from a set of defaults
  function automatic logic [31:0] cap_w(input pmc_dflt_s d, input logic [7:0] nx);
    return {d.pme_sup, d.d2, d.d1, d.aux, d.dsi, 2'h0, 3'h3, nx, 8'h01};
  endfunction

  // Expected control word
  function automatic logic [31:0] ctl_w(input pmc_dflt_s d, input logic [1:0] st,
                                        input logic pe, input logic [3:0] ds);
    return {d.data, 8'h00, 3'h0, ds, pe, 4'h0, d.nsr, 1'h0, st};
  endfunction

  // Write with address and data offered together, response checked
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic done, ta, tw;
    done = 1'h0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    while (!done)
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      if (bvalid === 1'h1)
      begin
        check(bresp, er);
        done = 1'h1;
      end
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
  endtask

  // Read and compare data and response
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic done, ta;
    done = 1'h0;
    araddr  <= a;
    arvalid <= 1'h1;
    while (!done)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      if (rvalid === 1'h1)
      begin
        check(rdata, exp);
        check(rresp, er);
        done = 1'h1;
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end
  endtask

  // One-cycle default load pulse
  task automatic ld(input logic s, input logic e);
    sm_ld <= s;
    ee_ld <= e;
    @(posedge aclk);
    sm_ld <= 1'h0;
    ee_ld <= 1'h0;
    @(posedge aclk);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(PMC_OFF_CAP, 32'hFFC39C01, PMC_RESP_OKAY);
    axi_rd(PMC_OFF_CTL, 32'h00000008, PMC_RESP_OKAY);
    for (int s = 1; s < 4; s++)
    begin
      axi_wr(PMC_OFF_CTL, 32'hFFFFFFF4 | s, 4'hF, PMC_RESP_OKAY);
      axi_rd(PMC_OFF_CTL, 32'h1F08 | s, PMC_RESP_OKAY);
      check(pst, s);
    end
    check(pme_en, 1'h1);
    check(dsel, 4'hF);
    axi_wr(PMC_OFF_CTL, 32'h0, 4'h1, PMC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(hot_cnt, 1);
    check(irst_cnt, 0);
    check(pst, 2'h0);
    check(dsel, 4'hF);
    axi_wr(8'h88, 32'hFFFFFFFF, 4'hF, PMC_RESP_SLVERR);
    axi_rd(8'h81, 32'h0, PMC_RESP_SLVERR);
    axi_wr(PMC_OFF_CAP, 32'h0, 4'hF, PMC_RESP_OKAY);
    axi_rd(PMC_OFF_CAP, 32'hFFC39C01, PMC_RESP_OKAY);
    ld(1'h1, 1'h0);
    axi_rd(PMC_OFF_CAP, cap_w(sm_d, 8'h9C), PMC_RESP_OKAY);
    axi_rd(PMC_OFF_CTL, ctl_w(sm_d, 2'h0, 1'h1, 4'hF), PMC_RESP_OKAY);
    ld(1'h1, 1'h1);
    axi_rd(PMC_OFF_CAP, cap_w(ee_d, 8'h9C), PMC_RESP_OKAY);
    axi_rd(PMC_OFF_CTL, ctl_w(ee_d, 2'h0, 1'h1, 4'hF), PMC_RESP_OKAY);
    axi_wr(PMC_OFF_CTL, 32'hFFFFFFF7, 4'hF, PMC_RESP_OKAY);
    axi_wr(PMC_OFF_CTL, 32'h0, 4'h1, PMC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(hot_cnt, 2);
    check(irst_cnt, 1);
    axi_rd(PMC_OFF_CTL, ctl_w(ee_d, 2'h0, 1'h1, 4'h0), PMC_RESP_OKAY);
    up      <= 1'h0;
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(PMC_OFF_CAP, 32'hFFC38C01, PMC_RESP_OKAY);
    check(pme_en, 1'h0);
    axi_wr(PMC_OFF_CTL, 32'h00001403, 4'h2, PMC_RESP_OKAY);
    axi_rd(PMC_OFF_CTL, 32'h00001408, PMC_RESP_OKAY);
    check(dsel, 4'hA);
    check(dsr_low, 0);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
